// file: hdl/sgcr_pkg.sv
// Purpose: Constants of the global control register bank.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Register indices are kept; byte address is four times the index.
package sgcr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned GCTL_FIRST_IDX = 2;
    localparam int unsigned GCTL_SECOND_IDX = 3;
    localparam logic [7:0] GCTL_FIRST_ADDR = 8'(GCTL_FIRST_IDX * 4);
    localparam logic [7:0] GCTL_SECOND_ADDR = 8'(GCTL_SECOND_IDX * 4);

    // ------------------------------------------------------------
    // First register fields
    // ------------------------------------------------------------
    localparam int unsigned F_MII_EN = 3;
    localparam int unsigned F_BUF_SHARE = 2;
    localparam int unsigned F_DROP_MODE = 1;
    localparam int unsigned F_LINK_AGE = 0;
    localparam logic [7:0] GCTL_FIRST_RST = 8'h44;

    // ------------------------------------------------------------
    // Second register fields
    // ------------------------------------------------------------
    localparam int unsigned F_PASS_ALL = 7;
    localparam int unsigned F_TX_PAUSE_DIS = 5;
    localparam int unsigned F_RX_PAUSE_DIS = 4;
    localparam int unsigned F_LEN_CHECK = 3;
    localparam int unsigned F_AGING_EN = 2;
    localparam int unsigned F_FAST_AGE = 1;
    localparam logic [7:0] GCTL_SECOND_RST = 8'h00;

    // ------------------------------------------------------------
    // Strap order on the sampler
    // ------------------------------------------------------------
    localparam int unsigned STRAP_MII = 0;
    localparam int unsigned STRAP_AGING = 1;
    localparam int unsigned STRAP_PAUSE = 2;
    localparam int unsigned N_STRAPS = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned FAST_AGE_US = 800;
    localparam int unsigned NORMAL_AGE_S = 300;
    localparam int unsigned NORMAL_AGE_US = NORMAL_AGE_S * 1000000;
    localparam int unsigned STRAP_SETTLE = 3;

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
    localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05dc;
    localparam int unsigned BUF_SHARE_DIV = 5;
endpackage

// file: hdl/sgcr_strap.sv
// Purpose: Synchronise strap pins and load them once after reset.
// Assumes: Pins are static while the chip leaves reset.
// Notes: Load is a one-cycle pulse; later pin changes are ignored.
`timescale 1ns/1ps
module sgcr_strap
    import sgcr_pkg::*;
#(
    parameter int unsigned N = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and results
    input wire logic [N-1:0] pins,
    output logic [N-1:0] value_q,
    output logic load_q
);
    logic [N-1:0] s1_q, s2_q, s3_q;
    logic [1:0] settle_q;
    logic done_q;

    // Three flops; only the second and third are compared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Capture once after release, once settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_q <= '0;
            done_q <= 1'b0;
            load_q <= 1'b0;
            value_q <= '0;
        end else begin
            load_q <= 1'b0;
            if (settle_q != 2'(STRAP_SETTLE)) begin
                settle_q <= settle_q + 2'd1;
            end else if (!done_q && s2_q == s3_q) begin
                done_q <= 1'b1;
                load_q <= 1'b1;
                value_q <= s3_q;
            end
        end
    end
endmodule

// file: hdl/sgcr_age.sv
// Purpose: Address-table aging period timer, normal and fast.
// Assumes: tick is a one-cycle pulse every microsecond.
// Notes: A link-triggered pass restarts the count at the fast period.
`timescale 1ns/1ps
module sgcr_age
    import sgcr_pkg::*;
#(
    parameter int unsigned CNT_W = 29,
    parameter int unsigned NORMAL_US = NORMAL_AGE_US,
    parameter int unsigned FAST_US = FAST_AGE_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic aging_en,
    input wire logic fast_en,
    input wire logic link_req,
    // Status
    output logic pass_q,
    output logic pending_q
);
    localparam logic [CNT_W-1:0] NORM_END = CNT_W'(NORMAL_US - 1);
    localparam logic [CNT_W-1:0] FAST_END = CNT_W'(FAST_US - 1);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] end_cnt;
    logic at_end;

    if (FAST_US < 1 || NORMAL_US < FAST_US || NORMAL_US > 2**CNT_W) begin
        $error("sgcr_age: bad periods");
    end

    // Fast period while fast age is on or a link pass is owed
    assign end_cnt = (fast_en || pending_q) ? FAST_END : NORM_END;
    assign at_end = tick && (cnt_q >= end_cnt);

    // Microsecond counter; a link event restarts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!aging_en || link_req) begin
            cnt_q <= '0;
        end else if (at_end) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // Owed link pass; a new request wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (link_req && aging_en) begin
            pending_q <= 1'b1;
        end else if (at_end || !aging_en) begin
            pending_q <= 1'b0;
        end
    end

    // One pulse per completed period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pass_q <= 1'b0;
        end else begin
            pass_q <= aging_en && !link_req && at_end;
        end
    end
endmodule

// file: hdl/sgcr_top.sv
// Purpose: Global switch control bits on APB and what they steer.
// Assumes: Switch-core inputs share pclk; strap pins are asynchronous.
// Notes: APB stalls until straps are loaded.
//
// Overview of operation
// - First control register sits at index 0x02.
// - Clear PHY MII enable tri-states all MII outputs.
// - Buffer share set (reset) lets a port borrow idle buffers.
// - Buffer share clear limits each port to one fifth of the pool.
// - Drop mode set drops 0x8808 or pause DA; clear drops flow frames.
// - Link age set: link loss starts one fast pass under 800us.
// - After the link pass aging returns to the 300 s period.
// - Pass-all bit 7 forwards every frame including bad ones; resets 0.
// - Transmit pause disable bit 5 overrides negotiated pause.
// - Receive pause disable bit 4 overrides negotiated pause.
// - One strap sets both pause disable bits; software writes each.
// - Length check drops frames whose length field below 1500 mismatches.
// - Aging enable bit 2 turns aging on; reset value from a strap.
// - Fast age enable bit selects the 800us period; resets to 0.
`timescale 1ns/1ps
module sgcr_top
    import sgcr_pkg::*;
#(
    parameter int unsigned N_PORTS = 5,
    parameter int unsigned BUF_W = 10,
    parameter int unsigned BUF_TOTAL = 512,
    parameter int unsigned AGE_CNT_W = 29,
    parameter int unsigned NORMAL_US = NORMAL_AGE_US,
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap pins
    input wire logic phy_mii_enable_strap_pin,
    input wire logic aging_enable_strap_pin,
    input wire logic pause_disable_strap_pin,
    // PHY-mode MII port
    output logic mii_out_en_q,
    // Link state and negotiated pause per port
    input wire logic [N_PORTS-1:0] link_up,
    input wire logic [N_PORTS-1:0] an_tx_pause,
    input wire logic [N_PORTS-1:0] an_rx_pause,
    output logic [N_PORTS-1:0] tx_fc_en_q,
    output logic [N_PORTS-1:0] rx_fc_en_q,
    // Received frame classification
    input wire logic frm_valid,
    input wire logic [15:0] frm_type_len,
    input wire logic [47:0] frm_da,
    input wire logic frm_is_flow_ctrl,
    input wire logic [15:0] frm_len_actual,
    input wire logic frm_err,
    output logic frm_done_q,
    output logic frm_forward_q,
    // Buffer admission
    input wire logic buf_req,
    input wire logic [BUF_W-1:0] buf_port_used,
    input wire logic [BUF_W-1:0] buf_pool_free,
    output logic buf_done_q,
    output logic buf_grant_q,
    // Aging
    output logic age_pass_q,
    output logic age_fast_q
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (N_PORTS < 1 || BUF_TOTAL < BUF_SHARE_DIV ||
        BUF_TOTAL >= 2**BUF_W || TICK_DIV < 2 || TICK_DIV > 255) begin
        $error("sgcr_top: bad parameters");
    end

    localparam logic [BUF_W-1:0] PORT_LIMIT =
        BUF_W'(BUF_TOTAL / BUF_SHARE_DIV);
    localparam logic [7:0] TICK_END = 8'(TICK_DIV - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] first_q;
    logic [7:0] second_q;
    logic [N_STRAPS-1:0] strap_val;
    logic strap_load;
    logic ready_ok_q;
    logic acc_phase;
    logic wr_go;
    logic hit_first;
    logic hit_second;
    logic [7:0] rd_mux;
    logic [7:0] tick_cnt_q;
    logic tick_q;
    logic [N_PORTS-1:0] link_prev_q;
    logic link_req_q;
    logic age_pass;
    logic age_pending;
    logic is_pause;
    logic len_bad;
    logic drop;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    sgcr_strap #(
        .N(N_STRAPS)
    ) u_strap (
        .clk(pclk),
        .rst_n(presetn),
        .pins({pause_disable_strap_pin, aging_enable_strap_pin,
               phy_mii_enable_strap_pin}),
        .value_q(strap_val),
        .load_q(strap_load)
    );

    // Bus stays stalled until straps are in, so software never races them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ok_q <= 1'b0;
        end else if (strap_load) begin
            ready_ok_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign acc_phase = psel && penable;
    assign hit_first = (paddr == GCTL_FIRST_ADDR);
    assign hit_second = (paddr == GCTL_SECOND_ADDR);
    assign wr_go = acc_phase && pready && pwrite && pstrb[0] && !pslverr;

    // Read multiplexer; unmapped reads return zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_first) begin
            rd_mux = first_q;
        end else if (hit_second) begin
            rd_mux = second_q;
        end
    end

    // One wait state: answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (acc_phase && !pready && ready_ok_q) begin
            pready <= 1'b1;
            pslverr <= !(hit_first || hit_second);
            prdata <= {24'h00_0000, rd_mux};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // First control register
    // ------------------------------------------------------------
    // Upper nibble is plain storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= GCTL_FIRST_RST;
        end else if (strap_load) begin
            first_q[F_MII_EN] <= strap_val[STRAP_MII];
        end else if (wr_go && hit_first) begin
            first_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Second control register
    // ------------------------------------------------------------
    // One strap feeds both pause bits; writes set each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_q <= GCTL_SECOND_RST;
        end else if (strap_load) begin
            second_q[F_TX_PAUSE_DIS] <= strap_val[STRAP_PAUSE];
            second_q[F_RX_PAUSE_DIS] <= strap_val[STRAP_PAUSE];
            second_q[F_AGING_EN] <= strap_val[STRAP_AGING];
        end else if (wr_go && hit_second) begin
            second_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // MII isolation
    // ------------------------------------------------------------
    // Output enable of the MII pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mii_out_en_q <= 1'b0;
        end else begin
            mii_out_en_q <= first_q[F_MII_EN];
        end
    end

    // ------------------------------------------------------------
    // Pause resolution
    // ------------------------------------------------------------
    // Disable bits override whatever negotiation resolved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_fc_en_q <= '0;
            rx_fc_en_q <= '0;
        end else begin
            tx_fc_en_q <= an_tx_pause &
                {N_PORTS{!second_q[F_TX_PAUSE_DIS]}};
            rx_fc_en_q <= an_rx_pause &
                {N_PORTS{!second_q[F_RX_PAUSE_DIS]}};
        end
    end

    // ------------------------------------------------------------
    // Frame filter
    // ------------------------------------------------------------
    // Pause match depends on drop mode
    assign is_pause = first_q[F_DROP_MODE] ?
        (frm_type_len == PAUSE_TYPE || frm_da == PAUSE_DA) :
        frm_is_flow_ctrl;
    // Only length-style frames are checked
    assign len_bad = second_q[F_LEN_CHECK] &&
        (frm_type_len < LEN_FIELD_LIMIT) &&
        (frm_type_len != frm_len_actual);
    assign drop = is_pause || len_bad || frm_err;

    // Pass-all is a debug override, so it beats every drop reason
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_done_q <= 1'b0;
            frm_forward_q <= 1'b0;
        end else begin
            frm_done_q <= frm_valid;
            if (frm_valid) begin
                frm_forward_q <= second_q[F_PASS_ALL] || !drop;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer admission
    // ------------------------------------------------------------
    // Shared pool ignores the per-port cap; otherwise one fifth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_done_q <= 1'b0;
            buf_grant_q <= 1'b0;
        end else begin
            buf_done_q <= buf_req;
            if (buf_req) begin
                if (first_q[F_BUF_SHARE]) begin
                    buf_grant_q <= (buf_pool_free != '0);
                end else begin
                    buf_grant_q <= (buf_pool_free != '0) &&
                        (buf_port_used < PORT_LIMIT);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------
    // Divider gives a one-cycle enable; avoids a 36-bit cycle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_END) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Link-loss detection
    // ------------------------------------------------------------
    // Any port losing link requests one fast pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_prev_q <= '0;
            link_req_q <= 1'b0;
        end else begin
            link_prev_q <= link_up;
            link_req_q <= first_q[F_LINK_AGE] &&
                ((link_prev_q & ~link_up) != '0);
        end
    end

    // ------------------------------------------------------------
    // Aging timer
    // ------------------------------------------------------------
    sgcr_age #(
        .CNT_W(AGE_CNT_W),
        .NORMAL_US(NORMAL_US),
        .FAST_US(FAST_AGE_US)
    ) u_age (
        .clk(pclk),
        .rst_n(presetn),
        .tick(tick_q),
        .aging_en(second_q[F_AGING_EN]),
        .fast_en(second_q[F_FAST_AGE]),
        .link_req(link_req_q),
        .pass_q(age_pass),
        .pending_q(age_pending)
    );

    // Registered copies for the switch core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_pass_q <= 1'b0;
            age_fast_q <= 1'b0;
        end else begin
            age_pass_q <= age_pass;
            age_fast_q <= age_pending || second_q[F_FAST_AGE];
        end
    end
endmodule

// file: tb/sgcr_chk_sva.sv
// Purpose: Port-level checks of the control register bank.
// Assumes: One clock domain, presetn asynchronous and active low.
// Notes: Register state is hidden, so checks tie outputs to inputs.
`timescale 1ns/1ps
module sgcr_chk #(
    parameter int unsigned N_PORTS = 5,
    parameter int unsigned BUF_W = 10
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Steered outputs
    input wire logic [N_PORTS-1:0] an_tx_pause,
    input wire logic [N_PORTS-1:0] an_rx_pause,
    input wire logic [N_PORTS-1:0] tx_fc_en_q,
    input wire logic [N_PORTS-1:0] rx_fc_en_q,
    input wire logic frm_valid,
    input wire logic frm_done_q,
    input wire logic buf_req,
    input wire logic [BUF_W-1:0] buf_pool_free,
    input wire logic buf_done_q,
    input wire logic buf_grant_q,
    input wire logic age_pass_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    addr_decode_a: assert property (psel && penable && pready |->
        pslverr == (paddr != 8'h08 && paddr != 8'h0c))
        else $error("pslverr wrong");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");

    // ------------------------------------------------------------
    // Steering
    // ------------------------------------------------------------
    // A disable bit may only remove pause, never add it
    tx_pause_gate_a: assert property (
        (tx_fc_en_q & ~$past(an_tx_pause)) == '0)
        else $error("tx pause not negotiated");
    rx_pause_gate_a: assert property (
        (rx_fc_en_q & ~$past(an_rx_pause)) == '0)
        else $error("rx pause not negotiated");
    frame_done_a: assert property (frm_done_q == $past(frm_valid))
        else $error("frame verdict late");
    buf_done_a: assert property (buf_done_q == $past(buf_req))
        else $error("buffer verdict late");
    empty_pool_a: assert property (
        buf_req && buf_pool_free == '0 |=> !buf_grant_q)
        else $error("grant from empty pool");
    age_pulse_a: assert property (age_pass_q |=> !age_pass_q)
        else $error("aging pass too long");

    cover property (psel && penable && pslverr);
    cover property (buf_req && buf_pool_free == '0);
    cover property (age_pass_q);
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the global control register bank.
// Assumes: Bench is APB master and drives all core inputs.
// Notes: Aging periods shortened by parameters.
`timescale 1ns/1ps
module tb;
    import sgcr_pkg::*;
    localparam int unsigned TD = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0, rdv;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, mii_q, fdone, ffwd, bdone, bgrant, apass, afast;
    logic s_mii = 1, s_age = 1, s_pause = 1, fval = 0, ffc = 0, ferr = 0;
    logic breq = 0, er;
    logic [4:0] link = 5'h1f, an_tx = 5'h1f, an_rx = 5'h1f, txq, rxq;
    logic [15:0] ftl = '0, flen = '0;
    logic [47:0] fda = '0;
    logic [9:0] bused = '0, bfree = '0;
    int n_fail = 0, total_checks = 0, n;

    // Free-running core clock, 8 ns
    always #4 pclk = ~pclk;

    sgcr_top #(.NORMAL_US(2000), .TICK_DIV(TD)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phy_mii_enable_strap_pin(s_mii), .aging_enable_strap_pin(s_age),
        .pause_disable_strap_pin(s_pause), .mii_out_en_q(mii_q),
        .link_up(link), .an_tx_pause(an_tx), .an_rx_pause(an_rx),
        .tx_fc_en_q(txq), .rx_fc_en_q(rxq), .frm_valid(fval),
        .frm_type_len(ftl), .frm_da(fda), .frm_is_flow_ctrl(ffc),
        .frm_len_actual(flen), .frm_err(ferr), .frm_done_q(fdone),
        .frm_forward_q(ffwd), .buf_req(breq), .buf_port_used(bused),
        .buf_pool_free(bfree), .buf_done_q(bdone), .buf_grant_q(bgrant),
        .age_pass_q(apass), .age_fast_q(afast));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Holds the request until pready; bounded wait
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 200);
        rdv = prdata[7:0];
        er = pslverr;
        if (k >= 200) begin
            chk(0, 1, "bus timeout");
            results;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic ee);
        apb(1'b0, a, 8'h00);
        chk({24'h0, rdv}, {24'h0, e}, "read data");
        chk({31'h0, er}, {31'h0, ee}, "error flag");
    endtask

    task automatic frm(input logic [15:0] tl, input logic [47:0] da,
                       input logic fc, input logic [15:0] ln,
                       input logic err, input logic exp);
        fval <= 1'b1;
        ftl <= tl;
        fda <= da;
        ffc <= fc;
        flen <= ln;
        ferr <= err;
        @(posedge pclk);
        fval <= 1'b0;
        @(posedge pclk);
        chk({30'h0, fdone, ffwd}, {30'h0, 1'b1, exp}, "frame verdict");
    endtask

    task automatic bf(input logic [9:0] used, input logic [9:0] free,
                      input logic exp);
        breq <= 1'b1;
        bused <= used;
        bfree <= free;
        @(posedge pclk);
        breq <= 1'b0;
        @(posedge pclk);
        chk({30'h0, bdone, bgrant}, {30'h0, 1'b1, exp}, "buffer grant");
    endtask

    // Edges to next aging pass, at most lim
    task automatic wait_pass(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apass !== 1'b1 && n < lim);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(GCTL_FIRST_ADDR, 8'h4c, 1'b0);
        s_mii <= 1'b0;
        s_age <= 1'b0;
        s_pause <= 1'b0;
        rd(GCTL_SECOND_ADDR, 8'h34, 1'b0);
        rd(GCTL_FIRST_ADDR, 8'h4c, 1'b0);
        chk({31'h0, mii_q}, 1, "mii enable");
        chk({22'h0, txq, rxq}, 0, "strap pause");
        rd(8'h10, 8'h00, 1'b1);
        $display("test straps done");
        apb(1'b1, GCTL_SECOND_ADDR, 8'h10);
        repeat (2) @(posedge pclk);
        chk({22'h0, txq, rxq}, {22'h0, 5'h1f, 5'h00}, "rx off");
        apb(1'b1, GCTL_SECOND_ADDR, 8'h20);
        repeat (2) @(posedge pclk);
        chk({22'h0, txq, rxq}, {22'h0, 5'h00, 5'h1f}, "tx off");
        $display("test pause disable done");
        apb(1'b1, GCTL_FIRST_ADDR, 8'hb0);
        rd(GCTL_FIRST_ADDR, 8'hb0, 1'b0);
        chk({31'h0, mii_q}, 0, "mii isolate");
        bf(10'd101, 10'd5, 1'b1);
        bf(10'd102, 10'd5, 1'b0);
        frm(16'h8808, 48'h0, 1'b0, 16'h0, 1'b0, 1'b1);
        frm(16'h0800, 48'h0, 1'b1, 16'h0, 1'b0, 1'b0);
        frm(16'h0040, 48'h0, 1'b0, 16'h0041, 1'b0, 1'b1);
        $display("test isolate done");
        apb(1'b1, GCTL_FIRST_ADDR, 8'h06);
        apb(1'b1, GCTL_SECOND_ADDR, 8'h08);
        bf(10'd500, 10'd1, 1'b1);
        bf(10'd500, 10'd0, 1'b0);
        frm(16'h8808, 48'h0, 1'b0, 16'h0, 1'b0, 1'b0);
        frm(16'h0800, PAUSE_DA, 1'b0, 16'h0, 1'b0, 1'b0);
        frm(16'h0040, 48'h0, 1'b0, 16'h0040, 1'b0, 1'b1);
        frm(16'h0040, 48'h0, 1'b0, 16'h0041, 1'b0, 1'b0);
        frm(16'h05dc, 48'h0, 1'b0, 16'h0, 1'b0, 1'b1);
        apb(1'b1, GCTL_SECOND_ADDR, 8'h88);
        frm(16'h0800, 48'h0, 1'b0, 16'h0, 1'b1, 1'b1);
        frm(16'h0040, 48'h0, 1'b0, 16'h0041, 1'b0, 1'b1);
        $display("test filters done");
        apb(1'b1, GCTL_SECOND_ADDR, 8'h06);
        wait_pass(9000);
        wait_pass(4000);
        chk({31'h0, n >= 3196 && n <= 3204}, 1, "fast period");
        apb(1'b1, GCTL_SECOND_ADDR, 8'h04);
        apb(1'b1, GCTL_FIRST_ADDR, 8'h01);
        link <= 5'h1b;
        repeat (4) @(posedge pclk);
        chk({31'h0, afast}, 1, "link pass owed");
        wait_pass(4000);
        chk({31'h0, n >= 3185 && n <= 3215}, 1, "link pass time");
        repeat (2) @(posedge pclk);
        chk({31'h0, afast}, 0, "back to normal");
        wait_pass(4000);
        chk(n, 4000, "no fast pass");
        $display("test aging done");
        results;
    end
endmodule

bind sgcr_top sgcr_chk #(.N_PORTS(N_PORTS), .BUF_W(BUF_W)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .an_tx_pause(an_tx_pause), .an_rx_pause(an_rx_pause),
    .tx_fc_en_q(tx_fc_en_q), .rx_fc_en_q(rx_fc_en_q),
    .frm_valid(frm_valid), .frm_done_q(frm_done_q), .buf_req(buf_req),
    .buf_pool_free(buf_pool_free), .buf_done_q(buf_done_q),
    .buf_grant_q(buf_grant_q), .age_pass_q(age_pass_q));
